// [common/sic_cfg.svh]
// constants of the status indicator controller: offsets, fields, resets, timing
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
// register byte offsets
`define SIC_OFS_CTRL        8'h00
`define SIC_OFS_CH_DEF      8'h04
`define SIC_OFS_CH_CABLE    8'h08
`define SIC_OFS_CH_WARN     8'h0c
`define SIC_OFS_CH_ALARM    8'h10
`define SIC_OFS_STATUS      8'h14
`define SIC_OFS_IRQ_STAT    8'h18
`define SIC_OFS_IRQ_MASK    8'h1c
`define SIC_OFS_NET_OWN     8'h20
`define SIC_OFS_NET_SERVER  8'h24
`define SIC_OFS_TREND_PTR   8'h28
`define SIC_OFS_SPEC_PTR    8'h2c
// control register fields
`define SIC_CTRL_BOOT_OK    0
`define SIC_CTRL_HALT       1
`define SIC_CTRL_CFG_DONE   2
`define SIC_CTRL_DATA_OK    3
`define SIC_CTRL_LINK_LO    4
`define SIC_CTRL_LINK_HI    5
`define SIC_CTRL_FAULT      6
`define SIC_CTRL_FAULT_BLK  7
// interrupt status fields
`define SIC_IRQ_CFG_DONE    0
`define SIC_IRQ_MEASURE     1
`define SIC_IRQ_ALARM       2
`define SIC_IRQ_DIG_A       3
`define SIC_IRQ_DIG_B       4
`define SIC_IRQ_WRAP        5
`define SIC_IRQ_W           6
// network defaults
`define SIC_NET_OWN_RST     32'h0a000065
`define SIC_NET_SERVER_RST  32'h0a000001
`define SIC_OCTET_MIN       8'h65
`define SIC_OCTET_MAX       8'hc7
// flash partition, bytes
`define SIC_FLASH_FW_BYTES     23'h200000
`define SIC_TREND_BASE         23'h200000
`define SIC_TREND_BYTES        23'h200000
`define SIC_SPEC_BASE          23'h400000
`define SIC_SPEC_BYTES         23'h400000
// timing
`define SIC_CLK_HZ          200000000
`define SIC_SETTLE_S        30
`define SIC_TICK_US         1000
`endif

// [common/sic_pkg.sv]
// types shared by the status indicator controller
package sic_pkg;
    typedef enum logic [1:0] {SIC_BOOT, SIC_CONFIG, SIC_SETTLE, SIC_MEASURE} sic_phase_t;
    typedef enum logic [1:0] {SIC_LINK_OFF, SIC_LINK_UP, SIC_LINK_TRY, SIC_LINK_FORCED} sic_link_t;
endpackage

// [design/sic_status_indicator.sv]
// front-panel status indicator controller with start-up sequencer
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sic_cfg.svh"

module sic_status_indicator #(
    parameter int            CHANNELS        = 16,
    parameter longint        SETTLE_CYCLES   = longint'(`SIC_SETTLE_S) * longint'(`SIC_CLK_HZ),
    parameter int            TICK_CYCLES     = (`SIC_TICK_US * (`SIC_CLK_HZ / 1000000)),
    parameter int            TOGGLE_HOLD     = 200,
    parameter logic [22:0]   TREND_ENTRY     = 23'h000010,
    parameter logic [22:0]   SPEC_ENTRY      = 23'h004000
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    output logic                       irq,
    input  wire logic                  nv_params_valid,
    input  wire logic [7:0]            rotary_sw,
    input  wire logic                  speed_input_a,
    input  wire logic                  speed_input_b,
    input  wire logic                  trend_store,
    input  wire logic                  spec_store,
    output logic      [22:0]           trend_addr,
    output logic      [22:0]           spec_addr,
    output logic      [31:0]           own_addr,
    output logic      [31:0]           server_addr,
    output logic                       main_start,
    output logic                       measure_en,
    output sic_pkg::sic_phase_t        phase,
    output logic      [CHANNELS-1:0]   channel_leds,
    output logic                       link_status_led,
    output logic                       system_status_led,
    output logic                       alarm_led,
    output logic                       error_led,
    output logic      [2:0]            comm_leds,
    output logic                       digital_input_led_a,
    output logic                       digital_input_led_b
);
    import sic_pkg::*;

    // ==================================================================
    // register file
    // ==================================================================
    logic [7:0]            ctrl_reg;
    logic [CHANNELS-1:0]   ch_def_reg, ch_cable_reg, ch_warn_reg, ch_alarm_reg;
    logic [`SIC_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
    logic [31:0]           net_own_reg, net_server_reg;
    logic                  own_written_reg;
    logic [31:0]           rdata_next;

    wire wr_ctrl   = reg_wr && reg_addr == `SIC_OFS_CTRL;
    wire wr_def    = reg_wr && reg_addr == `SIC_OFS_CH_DEF;
    wire wr_cable  = reg_wr && reg_addr == `SIC_OFS_CH_CABLE;
    wire wr_warn   = reg_wr && reg_addr == `SIC_OFS_CH_WARN;
    wire wr_alarm  = reg_wr && reg_addr == `SIC_OFS_CH_ALARM;
    wire wr_istat  = reg_wr && reg_addr == `SIC_OFS_IRQ_STAT;
    wire wr_imask  = reg_wr && reg_addr == `SIC_OFS_IRQ_MASK;
    wire wr_own    = reg_wr && reg_addr == `SIC_OFS_NET_OWN;
    wire wr_server = reg_wr && reg_addr == `SIC_OFS_NET_SERVER;

    wire       boot_ok   = ctrl_reg[`SIC_CTRL_BOOT_OK];
    wire       boot_halt = ctrl_reg[`SIC_CTRL_HALT];
    wire       cfg_done  = ctrl_reg[`SIC_CTRL_CFG_DONE];
    wire       data_ok   = ctrl_reg[`SIC_CTRL_DATA_OK];
    wire       sys_fault = ctrl_reg[`SIC_CTRL_FAULT];
    wire       fault_blk = ctrl_reg[`SIC_CTRL_FAULT_BLK];
    wire [1:0] link_mode = ctrl_reg[`SIC_CTRL_LINK_HI:`SIC_CTRL_LINK_LO];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg       <= 8'h00;
            ch_def_reg     <= '0;
            ch_cable_reg   <= '0;
            ch_warn_reg    <= '0;
            ch_alarm_reg   <= '0;
            irq_mask_reg   <= '0;
            net_server_reg <= `SIC_NET_SERVER_RST;
        end else begin
            if (wr_ctrl)   ctrl_reg       <= reg_wdata[7:0];
            if (wr_def)    ch_def_reg     <= reg_wdata[CHANNELS-1:0];
            if (wr_cable)  ch_cable_reg   <= reg_wdata[CHANNELS-1:0];
            if (wr_warn)   ch_warn_reg    <= reg_wdata[CHANNELS-1:0];
            if (wr_alarm)  ch_alarm_reg   <= reg_wdata[CHANNELS-1:0];
            if (wr_imask)  irq_mask_reg   <= reg_wdata[`SIC_IRQ_W-1:0];
            if (wr_server) net_server_reg <= reg_wdata;
        end
    end

    // a written own address overrides the switch until the next reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            net_own_reg     <= `SIC_NET_OWN_RST;
            own_written_reg <= 1'b0;
        end else if (wr_own) begin
            net_own_reg     <= reg_wdata;
            own_written_reg <= 1'b1;
        end
    end

    // set wins over a write-one clear in the same cycle
    wire [`SIC_IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata[`SIC_IRQ_W-1:0] : '0;
    always_ff @(posedge clk_sys) begin
        if (rst) irq_stat_reg <= '0;
        else     irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ==================================================================
    // address selection
    // ==================================================================
    wire       sw_in_range = rotary_sw >= `SIC_OCTET_MIN && rotary_sw <= `SIC_OCTET_MAX;
    wire [7:0] own_octet   = sw_in_range ? rotary_sw : net_own_reg[7:0];
    wire [31:0] own_next   = own_written_reg ? net_own_reg : {net_own_reg[31:8], own_octet};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            own_addr    <= `SIC_NET_OWN_RST;
            server_addr <= `SIC_NET_SERVER_RST;
        end else begin
            own_addr    <= own_next;
            server_addr <= net_server_reg;
        end
    end

    // ==================================================================
    // start-up sequencer
    // ==================================================================
    sic_phase_t phase_reg, phase_next;
    logic [33:0] settle_cnt_reg;
    logic        auto_start_reg, auto_armed_reg;

    // the persisted-parameter strap is caught on the first clocked cycle after reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            auto_armed_reg <= 1'b1;
            auto_start_reg <= 1'b0;
        end else if (auto_armed_reg) begin
            auto_armed_reg <= 1'b0;
            auto_start_reg <= nv_params_valid;
        end
    end

    wire launch      = boot_ok || boot_halt || auto_start_reg;
    wire settle_last = settle_cnt_reg == 34'(SETTLE_CYCLES - 1);

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            SIC_BOOT:    if (launch) phase_next = SIC_CONFIG;
            SIC_CONFIG:  if (cfg_done) phase_next = SIC_SETTLE;
            SIC_SETTLE:  if (settle_last) phase_next = SIC_MEASURE;
            SIC_MEASURE: phase_next = SIC_MEASURE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_reg      <= SIC_BOOT;
            settle_cnt_reg <= '0;
        end else begin
            phase_reg      <= phase_next;
            if (phase_reg == SIC_SETTLE) settle_cnt_reg <= settle_cnt_reg + 34'd1;
            else                         settle_cnt_reg <= '0;
        end
    end

    assign phase      = phase_reg;
    assign measure_en = phase_reg == SIC_MEASURE;
    assign main_start = phase_reg == SIC_BOOT && launch;

    // ==================================================================
    // shared blink time base
    // ==================================================================
    logic [31:0] tick_cnt_reg;
    logic [9:0]  blink_reg;
    wire tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            blink_reg    <= '0;
        end else begin
            tick_cnt_reg <= tick ? 32'd0 : tick_cnt_reg + 32'd1;
            if (tick) blink_reg <= blink_reg + 10'd1;
        end
    end
    // both rates are bits of one counter, so all leds of one rate flash in phase
    wire slow_on = blink_reg[9];
    wire fast_on = blink_reg[7];

    // ==================================================================
    // led patterns
    // ==================================================================
    wire alarm_live = measure_en && data_ok;
    logic [CHANNELS-1:0] ch_led_next;

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            wire warned = alarm_live && (ch_warn_reg[gi] || ch_alarm_reg[gi]);
            assign ch_led_next[gi] = !ch_def_reg[gi] ? 1'b0 :
                                     warned          ? fast_on :
                                     ch_cable_reg[gi] ? slow_on : 1'b1;
        end
    endgenerate

    wire any_alarm = alarm_live && |(ch_alarm_reg & ch_def_reg);
    wire any_warn  = alarm_live && |(ch_warn_reg & ch_def_reg);
    wire alarm_led_next = any_alarm ? slow_on : any_warn;

    logic link_led_next;
    always_comb begin
        unique case (sic_link_t'(link_mode))
            SIC_LINK_OFF:    link_led_next = 1'b0;
            SIC_LINK_UP:     link_led_next = 1'b1;
            SIC_LINK_TRY:    link_led_next = slow_on;
            SIC_LINK_FORCED: link_led_next = fast_on;
        endcase
    end

    wire sys_led_next = phase_reg == SIC_BOOT   ? 1'b0 :
                        phase_reg == SIC_CONFIG ? slow_on : 1'b1;
    wire err_led_next = sys_fault && (!fault_blk || slow_on);

    // ==================================================================
    // digital input activity
    // ==================================================================
    logic [1:0] din, din_prev_reg, din_led_next, din_edge;
    logic [15:0] hold_reg [2];
    assign din = {speed_input_b, speed_input_a};
    generate
        for (gi = 0; gi < 2; gi++) begin : g_din
            assign din_edge[gi] = din[gi] != din_prev_reg[gi];
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    din_prev_reg[gi] <= 1'b0;
                    hold_reg[gi]     <= '0;
                end else begin
                    din_prev_reg[gi] <= din[gi];
                    if (din_edge[gi])        hold_reg[gi] <= 16'(TOGGLE_HOLD);
                    else if (hold_reg[gi] != 16'h0000 && tick) hold_reg[gi] <= hold_reg[gi] - 16'd1;
                end
            end
            // a recent edge means toggling; otherwise follow the level
            assign din_led_next[gi] = hold_reg[gi] != 16'h0000 ? fast_on : din[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            channel_leds        <= '0;
            link_status_led     <= 1'b0;
            system_status_led   <= 1'b0;
            alarm_led           <= 1'b0;
            error_led           <= 1'b0;
            digital_input_led_a <= 1'b0;
            digital_input_led_b <= 1'b0;
        end else begin
            channel_leds        <= ch_led_next;
            link_status_led     <= link_led_next;
            system_status_led   <= sys_led_next;
            alarm_led           <= alarm_led_next;
            error_led           <= err_led_next;
            digital_input_led_a <= din_led_next[0];
            digital_input_led_b <= din_led_next[1];
        end
    end
    assign comm_leds = 3'b000;

    // ==================================================================
    // circular flash buffers
    // ==================================================================
    localparam logic [22:0] REG_BASE [2] = '{`SIC_TREND_BASE, `SIC_SPEC_BASE};
    localparam logic [22:0] REG_SIZE [2] = '{`SIC_TREND_BYTES, `SIC_SPEC_BYTES};
    localparam logic [22:0] REG_STEP [2] = '{TREND_ENTRY, SPEC_ENTRY};
    logic [22:0] wr_off_reg [2];
    logic [1:0]  wrapped_reg, store, wrap_ev;
    assign store = {spec_store, trend_store};
    generate
        for (gi = 0; gi < 2; gi++) begin : g_buf
            // no room for one more entry: restart at the oldest one
            wire [23:0] nxt = {1'b0, wr_off_reg[gi]} + {1'b0, REG_STEP[gi]};
            assign wrap_ev[gi] = store[gi] && (nxt > {1'b0, REG_SIZE[gi]} - {1'b0, REG_STEP[gi]});
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    wr_off_reg[gi]  <= '0;
                    wrapped_reg[gi] <= 1'b0;
                end else if (store[gi]) begin
                    wr_off_reg[gi]  <= wrap_ev[gi] ? 23'h000000 : nxt[22:0];
                    if (wrap_ev[gi]) wrapped_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate
    assign trend_addr = REG_BASE[0] + wr_off_reg[0];
    assign spec_addr  = REG_BASE[1] + wr_off_reg[1];

    // ==================================================================
    // events and read-back
    // ==================================================================
    logic alarm_prev_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) alarm_prev_reg <= 1'b0;
        else     alarm_prev_reg <= any_alarm;
    end
    assign irq_ev[`SIC_IRQ_CFG_DONE] = phase_reg == SIC_CONFIG && cfg_done;
    assign irq_ev[`SIC_IRQ_MEASURE]  = phase_reg == SIC_SETTLE && settle_last;
    assign irq_ev[`SIC_IRQ_ALARM]    = any_alarm && !alarm_prev_reg;
    assign irq_ev[`SIC_IRQ_DIG_A]    = din_edge[0];
    assign irq_ev[`SIC_IRQ_DIG_B]    = din_edge[1];
    assign irq_ev[`SIC_IRQ_WRAP]     = |wrap_ev;

    wire [31:0] status_word = {16'h0000, own_addr[7:0], 1'b0, wrapped_reg, auto_start_reg,
                               alarm_live, phase_reg, measure_en};
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (reg_addr)
            `SIC_OFS_CTRL:       rdata_next = {24'h000000, ctrl_reg};
            `SIC_OFS_CH_DEF:     rdata_next = 32'(ch_def_reg);
            `SIC_OFS_CH_CABLE:   rdata_next = 32'(ch_cable_reg);
            `SIC_OFS_CH_WARN:    rdata_next = 32'(ch_warn_reg);
            `SIC_OFS_CH_ALARM:   rdata_next = 32'(ch_alarm_reg);
            `SIC_OFS_STATUS:     rdata_next = status_word;
            `SIC_OFS_IRQ_STAT:   rdata_next = 32'(irq_stat_reg);
            `SIC_OFS_IRQ_MASK:   rdata_next = 32'(irq_mask_reg);
            `SIC_OFS_NET_OWN:    rdata_next = own_addr;
            `SIC_OFS_NET_SERVER: rdata_next = server_addr;
            `SIC_OFS_TREND_PTR:  rdata_next = {9'h000, trend_addr};
            `SIC_OFS_SPEC_PTR:   rdata_next = {9'h000, spec_addr};
            default:             rdata_next = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (rst)         reg_rdata <= 32'h00000000;
        else if (reg_rd) reg_rdata <= rdata_next;
    end

    // ==================================================================
    // assertions
    // ==================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_launch;     phase_reg == SIC_BOOT && launch; endsequence
    sequence s_configured; phase_reg == SIC_CONFIG && cfg_done; endsequence

    property p_undef_dark;
        !ch_def_reg[0] |=> !channel_leds[0];
    endproperty
    a_undef_dark: assert property (p_undef_dark) else $error("undefined channel led lit");

    property p_cable_slow;
        ch_def_reg[0] && ch_cable_reg[0] && !alarm_live |=> channel_leds[0] == $past(slow_on);
    endproperty
    a_cable_slow: assert property (p_cable_slow) else $error("cable fault pattern wrong");

    property p_link_up;
        link_mode == 2'd1 |=> link_status_led;
    endproperty
    a_link_up: assert property (p_link_up) else $error("link led not on when connected");

    property p_start_order;
        s_launch |=> phase_reg == SIC_CONFIG;
    endproperty
    a_start_order: assert property (p_start_order) else $error("launch did not enter config");

    property p_settle;
        s_configured |=> (phase_reg == SIC_SETTLE && !measure_en) [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("measuring before settle");

    property p_sys_steady;
        phase_reg == SIC_SETTLE |=> system_status_led;
    endproperty
    a_sys_steady: assert property (p_sys_steady) else $error("system led not steady");

    property p_alarm_gate;
        !alarm_live |=> !alarm_led;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate) else $error("alarm shown before data");

    property p_err;
        sys_fault && !fault_blk |=> error_led;
    endproperty
    a_err: assert property (p_err) else $error("error led off on fault");

    property p_comm_off;
        comm_leds == 3'b000;
    endproperty
    a_comm_off: assert property (p_comm_off) else $error("communication led lit");

    property p_wrap;
        wrap_ev[0] |=> trend_addr == `SIC_TREND_BASE;
    endproperty
    a_wrap: assert property (p_wrap) else $error("trend buffer did not wrap");

    property p_irq_set_wins;
        irq_ev[0] |=> irq_stat_reg[0];
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost on clear");

endmodule // sic_status_indicator
`default_nettype wire

// [tb/sic_panel_model.sv]
// far-side model: firmware-driven digital inputs and rotary switch
`timescale 1ns/1ps
`default_nettype none
module sic_panel_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] dig_cmd,
    output logic            speed_input_a,
    output logic            speed_input_b,
    output logic      [7:0] rotary_sw
);
    // =====================================
    // inputs change just after the edge, like a synchronised field signal
    initial begin
        speed_input_a = 1'b0;
        speed_input_b = 1'b0;
        rotary_sw     = 8'h70;
    end
    always @(posedge clk_sys) begin
        speed_input_a <= dig_cmd[0];
        speed_input_b <= dig_cmd[1];
    end
endmodule // sic_panel_model
`default_nettype wire

// [tb/status_indicator_controller_tb.sv]
// self-checking bench of the status indicator controller
`timescale 1ns/1ps
`default_nettype none
`include "sic_cfg.svh"
module status_indicator_controller_tb;
    import sic_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, irq, ms, me, lk, sy, al, er, da, db, sa, sb, ts;
    logic [7:0] reg_addr, rsw;
    logic [31:0] reg_wdata, reg_rdata, own, srv, v;
    logic [15:0] ch;
    logic [22:0] ta;
    logic [2:0] cm;
    logic [1:0] dig_cmd;
    sic_phase_t ph;
    int miscompares, cmp_count, cyc, tg, bad;
    // =====================================
    // half-region trend entries make the buffer wrap after two stores
    sic_status_indicator #(.SETTLE_CYCLES(20), .TICK_CYCLES(2), .TOGGLE_HOLD(4), .TREND_ENTRY(23'h100000)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .nv_params_valid(1'b0), .rotary_sw(rsw),
        .speed_input_a(sa), .speed_input_b(sb), .trend_store(ts), .spec_store(1'b0),
        .trend_addr(ta), .spec_addr(), .own_addr(own), .server_addr(srv), .main_start(ms),
        .measure_en(me), .phase(ph), .channel_leds(ch), .link_status_led(lk), .system_status_led(sy),
        .alarm_led(al), .error_led(er), .comm_leds(cm), .digital_input_led_a(da), .digital_input_led_b(db));
    sic_panel_model u_panel (.clk_sys(clk_sys), .dig_cmd(dig_cmd), .speed_input_a(sa),
        .speed_input_b(sb), .rotary_sw(rsw));
    // =====================================
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        // ceiling well above the few thousand cycles the scenarios need
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // read data stand from the cycle after the strobe until the next strobe
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic t_reset();
        chk(own, `SIC_NET_OWN_RST);
        chk(srv, `SIC_NET_SERVER_RST);
        chk({ch, lk, sy, al, er, da, db, ms, irq, me, cm}, 32'h0);
    endtask
    task automatic t_start();
        wr(`SIC_OFS_CH_DEF, 32'h0000_0007);
        repeat (3) @(posedge clk_sys);
        chk(ch, 16'h0007);
        wr(`SIC_OFS_CTRL, 32'h0000_0001);
        @(negedge clk_sys);
        chk(ms, 1'b1);
        repeat (4) @(posedge clk_sys);
        wr(`SIC_OFS_CTRL, 32'h0000_000d);
        wr(`SIC_OFS_CH_WARN, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk({me, al}, 2'b00);
        repeat (40) @(posedge clk_sys);
        chk({me, ph, sy}, {1'b1, SIC_MEASURE, 1'b1});
        rd(`SIC_OFS_STATUS, v);
        chk(v[15:8], 8'h70);
    endtask
    task automatic t_blink();
        wr(`SIC_OFS_CH_WARN, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(al, 1'b1);
        wr(`SIC_OFS_CH_ALARM, 32'h2);
        wr(`SIC_OFS_CH_CABLE, 32'h6);
        wr(`SIC_OFS_CTRL, 32'h0000_00ed);
        repeat (3) @(posedge clk_sys);
        // alarm beats cable fault, and every slow blinker runs in phase
        repeat (2100) begin
            @(negedge clk_sys);
            if (ch[1] !== v[0]) tg = tg + 1;
            v[0] = ch[1];
            if (ch[0] !== ch[1] || ch[2] !== lk || al !== lk || er !== lk) bad = bad + 1;
        end
        chk(bad, 0);
        chk(tg > 4 && cm === 3'h0, 1'b1);
    endtask
    task automatic t_irq();
        rd(`SIC_OFS_IRQ_STAT, v);
        chk(v[0], 1'b1);
        wr(`SIC_OFS_IRQ_MASK, 32'h1);
        @(negedge clk_sys);
        chk(irq, 1'b1);
        wr(`SIC_OFS_IRQ_STAT, 32'h1);
        @(negedge clk_sys);
        chk(irq, 1'b0);
        rd(8'h40, v);
        chk(v, 32'h0);
    endtask
    task automatic t_link();
        wr(`SIC_OFS_CTRL, 32'h0000_005d);
        repeat (3) @(posedge clk_sys);
        chk({lk, er}, 2'b11);
        wr(`SIC_OFS_CTRL, 32'h0000_000d);
        repeat (3) @(posedge clk_sys);
        chk(lk, 1'b0);
        wr(`SIC_OFS_CTRL, 32'h0000_003d);
        repeat (3) @(posedge clk_sys);
        bad = 0;
        // forced link must follow the fast rate of the warned channel 0
        repeat (600) begin
            @(negedge clk_sys);
            if (lk !== ch[0]) bad = bad + 1;
        end
        chk(bad, 0);
    endtask
    task automatic store_one();
        @(posedge clk_sys);
        ts <= 1'b1;
        @(posedge clk_sys);
        ts <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic t_buf();
        chk(ta, `SIC_TREND_BASE);
        store_one();
        chk(ta, `SIC_TREND_BASE + 23'h100000);
        store_one();
        chk(ta, `SIC_TREND_BASE);
        rd(`SIC_OFS_STATUS, v);
        chk(v[6:5], 2'b01);
    endtask
    task automatic t_dig();
        bad = 0;
        // a toggle every four cycles keeps the activity hold loaded
        for (int i = 0; i < 600; i++) begin
            @(posedge clk_sys);
            if (i % 4 == 0) dig_cmd <= {1'b0, ~dig_cmd[0]};
            if (i > 8 && da !== ch[0]) bad = bad + 1;
        end
        chk(bad, 0);
        dig_cmd <= 2'b01;
        repeat (40) @(posedge clk_sys);
        chk({da, db}, 2'b10);
    endtask
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, dig_cmd, ts} = '0;
        {miscompares, cmp_count, cyc, tg, bad} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_start();
        t_blink();
        t_link();
        t_irq();
        t_buf();
        t_dig();
        final_report();
    end
endmodule // status_indicator_controller_tb
`default_nettype wire
